/* svrm_top.sv */
/*
 * Supply voltage reset monitor: supply-rise reset and undervoltage
 * detector control, registers, reset-cause flags and interrupt.
 * Assumes comparator outcomes arrive synchronous to CLK_SYS and that
 * the analog side applies UV_LEVEL_SEL while UV_ENABLE is high.
 */
// Contract
// RQ1: a supply-rise reset clears the whole reset-cause register to zero.
// RQ2: writing byte zero or bit-clearing the enable bit stops the detector.
// RQ3: software writes zero to bits 2 to 6 of undervoltage_control.
// RQ4: software writes zero to bits 4 to 7 of the level select register.
// RQ5: a level write while the detector runs makes the level undefined.
// RQ6: software clears the enable bit before changing the level select.
// RQ7: setting reset mode while supply is above level gives no reset.
// RQ8: with mask clear, an interrupt may follow the setup at once.
// RQ9: reset mode asserts reset below level and releases on recovery.
// RQ10: supply-rise reset asserts and releases as supply crosses its level.
// RQ11: the undervoltage reset never resets the detector's own logic.
// RQ12: while any reset is asserted both clocks are held stopped; the code drives one CLK_STOP output.
// RQ13: software reads the reset-cause register by whole bytes only.
// RQ14: interrupt mode raises a request instead of reset, gated by mask.
`timescale 1ns/100ps
module svrm_top import svrm_pkg::*; (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic REG_BIT_WR,
	input wire logic [2:0] REG_BIT_NUM,
	output logic [7:0] REG_RDATA,
	// comparators and other reset sources
	input wire logic SUPPLY_BELOW_RISE,
	input wire logic SUPPLY_BELOW_LEVEL,
	input wire logic WDOG_RST_REQ,
	// analog control
	output logic UV_ENABLE,
	output logic [LEVEL_BITS-1:0] UV_LEVEL_SEL,
	output logic UV_LEVEL_VALID,
	// resets, clock stop and interrupt
	output logic RST_SUPPLY_RISE,
	output logic RST_UNDERVOLT,
	output logic CLK_STOP,
	output logic IRQ
);

	// ==========================================================
	// bit replace for single-bit writes
	function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] num, input logic val);
		logic [7:0] res;
		res = old;
		res[num] = val;
		return res;
	endfunction : bit_merge

	// ==========================================================
	// bus bundle and decode
	svrm_bus_t bus;
	assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD,
		bit_wr: REG_BIT_WR, bit_num: REG_BIT_NUM};

	wire any_wr = bus.wr || bus.bit_wr;
	wire sel_ctrl = (bus.addr == OFS_UV_CTRL);
	wire sel_level = (bus.addr == OFS_UV_LEVEL);
	wire sel_status = (bus.addr == OFS_IRQ_STATUS);
	wire sel_mask = (bus.addr == OFS_IRQ_MASK);
	wire wr_ctrl = any_wr && sel_ctrl;
	wire wr_level = any_wr && sel_level;

	// ==========================================================
	// state
	logic uv_enable;
	logic uv_mode;
	logic [LEVEL_BITS-1:0] level_sel;
	logic level_dirty;
	logic [7:0] cause;
	logic poc_rst;
	logic uv_rst;
	logic uv_event;
	logic uv_rst_q;
	logic [7:0] rdata;
	logic [IRQ_COUNT-1:0] irq_status;
	logic [IRQ_COUNT-1:0] irq_mask;
	svrm_uv_state_t uv_state;

	// ==========================================================
	// supply-rise reset follows its comparator
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			poc_rst <= 1'b0;
		else
			poc_rst <= SUPPLY_BELOW_RISE; // RQ10
	end

	// detector logic is cleared by the chip and supply-rise resets only
	wire block_rst = SYS_RST || poc_rst; // RQ11

	// ==========================================================
	// undervoltage_control: enable and mode; bits 2..6 and flag not stored
	svrm_uv_ctrl_t ctrl_rd;
	assign ctrl_rd = '{enable: uv_enable, zero: 5'h00, mode: uv_mode, flag: SUPPLY_BELOW_LEVEL};

	wire [7:0] ctrl_cur = {uv_enable, 5'h00, uv_mode, 1'b0};
	wire [7:0] next_ctrl = bus.wr ? bus.wdata : bit_merge(ctrl_cur, bus.bit_num, bus.wdata[0]);

	always_ff @(posedge CLK_SYS) begin
		if (block_rst) begin
			uv_enable <= RST_UV_CTRL[BIT_UV_ENABLE];
			uv_mode <= RST_UV_CTRL[BIT_UV_MODE];
		end else if (wr_ctrl) begin
			uv_enable <= next_ctrl[BIT_UV_ENABLE]; // RQ2
			uv_mode <= next_ctrl[BIT_UV_MODE];
		end
	end

	// ==========================================================
	// level select; a write while running leaves the level undefined
	wire [7:0] level_cur = {4'h0, level_sel};
	wire [7:0] next_level = bus.wr ? bus.wdata : bit_merge(level_cur, bus.bit_num, bus.wdata[0]);

	always_ff @(posedge CLK_SYS) begin
		if (block_rst) begin
			level_sel <= RST_UV_LEVEL;
			level_dirty <= 1'b0;
		end else begin
			if (wr_level)
				level_sel <= next_level[LEVEL_BITS-1:0];
			if (wr_level && uv_enable)
				level_dirty <= 1'b1; // RQ5
			else if (!uv_enable)
				level_dirty <= 1'b0;
		end
	end

	// ==========================================================
	// detector sequencing
	svrm_uv_fsm u_fsm (
		.clk(CLK_SYS),
		.rst(block_rst),
		.enable(uv_enable),
		.reset_mode(uv_mode),
		.below(SUPPLY_BELOW_LEVEL),
		.uv_reset(uv_rst),
		.uv_event(uv_event),
		.state(uv_state)
	);

	// edge of the undervoltage reset for the cause flag
	always_ff @(posedge CLK_SYS) begin
		if (block_rst)
			uv_rst_q <= 1'b0;
		else
			uv_rst_q <= uv_rst;
	end

	// ==========================================================
	// reset-cause flags: set by sources, wiped by supply-rise reset
	always_ff @(posedge CLK_SYS) begin
		if (block_rst) begin
			cause <= RST_CAUSE; // RQ1
		end else begin
			if (uv_rst && !uv_rst_q)
				cause[CAUSE_UV] <= 1'b1;
			if (WDOG_RST_REQ)
				cause[CAUSE_WDOG] <= 1'b1;
		end
	end

	// ==========================================================
	// interrupt: detection in interrupt mode, reset entry in reset mode
	wire [IRQ_COUNT-1:0] irq_set = {uv_rst && !uv_rst_q, uv_event}; // RQ14

	svrm_irq #(
		.N(IRQ_COUNT)
	) u_irq (
		.clk(CLK_SYS),
		.rst(block_rst),
		.set(irq_set),
		.clr_wr(bus.wr && sel_status),
		.mask_wr(bus.wr && sel_mask),
		.wdata(bus.wdata[IRQ_COUNT-1:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(IRQ) // RQ8
	);

	// ==========================================================
	// read mux; unmapped addresses read zero
	wire [7:0] rd_mux =
		(bus.addr == OFS_UV_CTRL) ? ctrl_rd :
		(bus.addr == OFS_UV_LEVEL) ? level_cur :
		(bus.addr == OFS_RST_CAUSE) ? cause :
		(bus.addr == OFS_IRQ_STATUS) ? {6'h00, irq_status} :
		(bus.addr == OFS_IRQ_MASK) ? {6'h00, irq_mask} : RD_UNMAPPED;

	// read data stand one cycle only
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			rdata <= RD_UNMAPPED;
		else if (bus.rd)
			rdata <= rd_mux;
		else
			rdata <= RD_UNMAPPED;
	end

	// ==========================================================
	// outputs
	assign REG_RDATA = rdata;
	assign UV_ENABLE = uv_enable;
	assign UV_LEVEL_SEL = level_sel;
	assign UV_LEVEL_VALID = !level_dirty;
	assign RST_SUPPLY_RISE = poc_rst;
	assign RST_UNDERVOLT = uv_rst; // RQ9
	assign CLK_STOP = SYS_RST || poc_rst || uv_rst; // RQ12

	// ==========================================================
	// checks
	a_poc_clears_flags: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ1
		poc_rst |=> (cause == 8'h00))
		else $error("cause flags not cleared by supply-rise reset");

	a_byte_zero_stops: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ2
		(bus.wr && sel_ctrl && bus.wdata == 8'h00) |=> !UV_ENABLE ##1 (uv_state == UV_STOPPED))
		else $error("byte write of zero did not stop detector");

	a_bit_clear_stops: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ2
		(bus.bit_wr && !bus.wr && sel_ctrl && bus.bit_num == 3'h7 && !bus.wdata[0]) |=> !UV_ENABLE)
		else $error("bit clear of enable did not stop detector");

	a_level_write_live: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ5
		(wr_level && uv_enable && !poc_rst) |=> !UV_LEVEL_VALID)
		else $error("level write while running not flagged");

	a_mode_set_above: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ7
		($rose(uv_mode) && !SUPPLY_BELOW_LEVEL) |=> !RST_UNDERVOLT)
		else $error("reset on mode set with supply above level");

	a_irq_after_setup: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ8
		(uv_event && !irq_mask[IRQ_UV_DETECT] && !poc_rst && !(bus.wr && (sel_mask || sel_status))) |=> IRQ)
		else $error("unmasked detection did not raise interrupt");

	a_uv_reset_follow: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ9
		(uv_enable && uv_mode && SUPPLY_BELOW_LEVEL && !poc_rst && !wr_ctrl) |=> RST_UNDERVOLT)
		else $error("undervoltage reset not asserted below level");

	a_uv_reset_release: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ9
		(RST_UNDERVOLT ##1 !SUPPLY_BELOW_LEVEL) |=> !RST_UNDERVOLT)
		else $error("undervoltage reset not released on recovery");

	a_poc_follow: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ10
		SUPPLY_BELOW_RISE |=> RST_SUPPLY_RISE ##1 ($past(SUPPLY_BELOW_RISE) == RST_SUPPLY_RISE))
		else $error("supply-rise reset does not follow comparator");

	a_uv_not_self: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ11
		(RST_UNDERVOLT && !poc_rst && !wr_ctrl && !wr_level) |=> ($stable(uv_enable) && $stable(level_sel)))
		else $error("undervoltage reset disturbed detector settings");

	a_clock_stopped: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ12
		(RST_SUPPLY_RISE || RST_UNDERVOLT) |-> CLK_STOP)
		else $error("clock not stopped during reset");

	a_irq_mode_no_rst: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ14
		(uv_enable && !uv_mode && !wr_ctrl && !poc_rst) |=> !RST_UNDERVOLT)
		else $error("interrupt mode produced a reset");

	a_poc_wipes_cause: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ1
		$fell(RST_SUPPLY_RISE) |-> (cause == 8'h00))
		else $error("cause flags set at end of supply-rise reset");

	a_poc_stops_uv: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ10
		RST_SUPPLY_RISE |=> (!UV_ENABLE && !RST_UNDERVOLT))
		else $error("supply-rise reset left detector running");

	a_uv_rst_cause: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ9
		($rose(RST_UNDERVOLT) && !poc_rst) |=> cause[CAUSE_UV])
		else $error("undervoltage reset not recorded as cause");

	a_uv_rst_origin: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ9
		RST_UNDERVOLT |-> ($past(uv_enable) && $past(uv_mode) && $past(SUPPLY_BELOW_LEVEL)))
		else $error("undervoltage reset without low supply in reset mode");

	a_stopped_no_rst: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ2
		!uv_enable |=> !RST_UNDERVOLT)
		else $error("stopped detector produced a reset");

	a_stopped_level_ok: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ5
		!uv_enable |=> UV_LEVEL_VALID)
		else $error("level still undefined with detector stopped");

	a_clock_runs: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ12
		(!SYS_RST && !RST_SUPPLY_RISE && !RST_UNDERVOLT) |-> !CLK_STOP)
		else $error("clock stopped with no reset asserted");

	a_masked_quiet: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ14
		(&irq_mask) |-> !IRQ)
		else $error("interrupt raised with every source masked");

	a_detect_origin: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ14
		$rose(irq_status[IRQ_UV_DETECT]) |-> ($past(SUPPLY_BELOW_LEVEL) && !$past(uv_mode)))
		else $error("detect request without low supply in interrupt mode");

endmodule : svrm_top

/* svrm_pkg.sv */
/*
 * Package for the supply voltage reset monitor: register offsets, field
 * positions, reset values, register layouts and the detector state type.
 * Assumes nothing of its surroundings; every design file imports it whole.
 */
package svrm_pkg;

	// ==========================================================
	// register offsets on the byte-wide register port
	localparam logic [7:0] OFS_UV_CTRL = 8'h00;
	localparam logic [7:0] OFS_UV_LEVEL = 8'h01;
	localparam logic [7:0] OFS_RST_CAUSE = 8'h02;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h03;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h04;

	// ==========================================================
	// field positions
	localparam logic [2:0] BIT_UV_ENABLE = 3'h7;
	localparam logic [2:0] BIT_UV_MODE = 3'h1;
	localparam int unsigned CAUSE_UV = 0;
	localparam int unsigned CAUSE_WDOG = 4;
	localparam int unsigned IRQ_UV_DETECT = 0;
	localparam int unsigned IRQ_UV_RESET = 1;
	localparam int unsigned IRQ_COUNT = 2;
	localparam int unsigned LEVEL_BITS = 4;

	// ==========================================================
	// values after reset
	localparam logic [7:0] RST_UV_CTRL = 8'h00;
	localparam logic [LEVEL_BITS-1:0] RST_UV_LEVEL = 4'h0;
	localparam logic [7:0] RST_CAUSE = 8'h00;
	localparam logic [IRQ_COUNT-1:0] RST_IRQ_MASK = 2'h3;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// ==========================================================
	// layouts
	typedef struct packed {
		logic enable;
		logic [4:0] zero;
		logic mode;
		logic flag;
	} svrm_uv_ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic bit_wr;
		logic [2:0] bit_num;
	} svrm_bus_t;

	typedef enum logic [1:0] {
		UV_STOPPED,
		UV_WATCH,
		UV_LOW_IRQ,
		UV_LOW_RESET
	} svrm_uv_state_t;

endpackage : svrm_pkg

/* svrm_uv_fsm.sv */
/*
 * Undervoltage detector sequencing: follows the comparator outcome and
 * turns it into a reset level or an interrupt event by mode.
 * Assumes its reset excludes the reset that it produces itself.
 */
`timescale 1ns/100ps
module svrm_uv_fsm import svrm_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control and comparator
	input wire logic enable,
	input wire logic reset_mode,
	input wire logic below,
	// results
	output logic uv_reset,
	output logic uv_event,
	output svrm_uv_state_t state
);

	// ==========================================================
	// next state from enable, mode and comparator
	svrm_uv_state_t next_state;
	always_comb begin
		next_state = UV_WATCH;
		case (state)
			default: begin
				if (!enable)
					next_state = UV_STOPPED;
				else if (below && reset_mode)
					next_state = UV_LOW_RESET; // RQ7
				else if (below)
					next_state = UV_LOW_IRQ;
				else
					next_state = UV_WATCH;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			state <= UV_STOPPED;
		else
			state <= next_state;
	end

	// reset follows the low state; event on entering interrupt low
	assign uv_reset = (state == UV_LOW_RESET);
	assign uv_event = (next_state == UV_LOW_IRQ) && (state != UV_LOW_IRQ);

endmodule : svrm_uv_fsm

/* svrm_irq.sv */
/*
 * Sticky interrupt status with write-one-to-clear, a mask of the same
 * layout (one masks) and one level interrupt output.
 * Assumes set pulses and write strobes synchronous to clk.
 */
`timescale 1ns/100ps
module svrm_irq import svrm_pkg::*; #(
	parameter int unsigned N = IRQ_COUNT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// events and software access
	input wire logic [N-1:0] set,
	input wire logic clr_wr,
	input wire logic mask_wr,
	input wire logic [N-1:0] wdata,
	// state
	output logic [N-1:0] status,
	output logic [N-1:0] mask,
	output logic irq
);

	// ==========================================================
	// set wins over a clear in the same cycle
	wire [N-1:0] clr = clr_wr ? wdata : '0;
	wire [N-1:0] next_status = (status & ~clr) | set;

	always_ff @(posedge clk) begin
		if (rst) begin
			status <= '0;
			mask <= RST_IRQ_MASK;
		end else begin
			status <= next_status;
			if (mask_wr)
				mask <= wdata;
		end
	end

	// high while any unmasked status bit is set
	assign irq = |(status & ~mask);

endmodule : svrm_irq

/* svrm_top_test.sv */
/*
 * Self-checking bench for the supply voltage reset monitor top.
 * Assumes the svrm_pkg package and svrm_top; drives every port itself.
 */
`timescale 1ns/100ps
module supply_voltage_reset_monitor_test import svrm_pkg::*;;
	// ==========================================================
	// stimulus and observed signals
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic reg_bit_wr = 1'b0;
	logic [2:0] reg_bit_num = 3'h0;
	logic below_rise = 1'b0;
	logic below_lvl = 1'b0;
	logic wdog = 1'b0;
	logic [7:0] reg_rdata;
	logic uv_enable;
	logic [LEVEL_BITS-1:0] uv_level_sel;
	logic uv_level_valid, rst_rise, rst_uv, clk_stop, irq;
	logic [3:0] v;
	int n_errors = 0;
	int n_checks = 0;

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	// ==========================================================
	// device under test
	svrm_top dut_u (
		.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_BIT_WR(reg_bit_wr), .REG_BIT_NUM(reg_bit_num), .REG_RDATA(reg_rdata),
		.SUPPLY_BELOW_RISE(below_rise), .SUPPLY_BELOW_LEVEL(below_lvl), .WDOG_RST_REQ(wdog),
		.UV_ENABLE(uv_enable), .UV_LEVEL_SEL(uv_level_sel), .UV_LEVEL_VALID(uv_level_valid),
		.RST_SUPPLY_RISE(rst_rise), .RST_UNDERVOLT(rst_uv), .CLK_STOP(clk_stop), .IRQ(irq)
	);

	// ==========================================================
	// report and compare
	task conclude;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	task chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_byte

	task chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_bit

	// expected control byte
	function automatic logic [7:0] ctrl_exp(input logic en, input logic md, input logic bl);
		return {en, 5'h00, md, bl};
	endfunction : ctrl_exp

	// ==========================================================
	// register port cycles
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task bwr(input logic [7:0] a, input logic [2:0] n, input logic b);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_bit_num <= n;
		reg_wdata <= {7'h00, b};
		reg_bit_wr <= 1'b1;
		@(posedge clk_sys);
		reg_bit_wr <= 1'b0;
		#1;
	endtask : bwr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk_byte(reg_rdata, exp);
	endtask : rd

	task step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task endtest(input string name);
		$display("done %s checks %0d errors %0d", name, n_checks, n_errors);
	endtask : endtest

	// ==========================================================
	// hang guard
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		conclude();
	end

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32'hCDD6));
		step(15);
		chk_bit(clk_stop, 1'b1);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		// reset values, read-only and unmapped places
		rd(OFS_UV_CTRL, RST_UV_CTRL);
		step(1);
		chk_byte(reg_rdata, RD_UNMAPPED);
		rd(OFS_UV_LEVEL, {4'h0, RST_UV_LEVEL});
		rd(OFS_RST_CAUSE, RST_CAUSE);
		rd(OFS_IRQ_STATUS, 8'h00);
		rd(OFS_IRQ_MASK, {6'h00, RST_IRQ_MASK});
		wr(OFS_RST_CAUSE, 8'hFF);
		wr(8'h05, 8'hFF);
		rd(OFS_RST_CAUSE, 8'h00);
		rd(8'h05, RD_UNMAPPED);
		chk_bit(uv_level_valid, 1'b1);
		endtest("registers");
		// both ways of stopping the detector
		wr(OFS_UV_CTRL, 8'h80);
		chk_bit(uv_enable, 1'b1);
		wr(OFS_UV_CTRL, 8'h00);
		chk_bit(uv_enable, 1'b0);
		wr(OFS_UV_CTRL, 8'h80);
		bwr(OFS_UV_CTRL, BIT_UV_ENABLE, 1'b0);
		chk_bit(uv_enable, 1'b0);
		rd(OFS_UV_CTRL, 8'h00);
		endtest("stop");
		// random levels with the detector stopped
		for (int i = 0; i < 8; i++) begin
			v = 4'($urandom);
			wr(OFS_UV_LEVEL, {4'h0, v});
			chk_byte({4'h0, uv_level_sel}, {4'h0, v});
			chk_bit(uv_level_valid, 1'b1);
			rd(OFS_UV_LEVEL, {4'h0, v});
		end
		// single-bit write into the level register
		bwr(OFS_UV_LEVEL, 3'h0, ~v[0]);
		rd(OFS_UV_LEVEL, {4'h0, v[3:1], ~v[0]});
		// level write while running
		wr(OFS_UV_CTRL, 8'h80);
		wr(OFS_UV_LEVEL, 8'h05);
		chk_bit(uv_level_valid, 1'b0);
		chk_byte({4'h0, uv_level_sel}, 8'h05);
		wr(OFS_UV_CTRL, 8'h00);
		step(1);
		chk_bit(uv_level_valid, 1'b1);
		endtest("level");
		// reset mode, supply hovering near the level
		wr(OFS_UV_CTRL, 8'h82);
		step(3);
		chk_bit(rst_uv, 1'b0);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			below_lvl <= 1'b1;
			step(1);
			chk_bit(rst_uv, 1'b1);
			chk_bit(clk_stop, 1'b1);
			rd(OFS_UV_CTRL, ctrl_exp(1'b1, 1'b1, 1'b1));
			@(posedge clk_sys);
			below_lvl <= 1'b0;
			step(1);
			chk_bit(rst_uv, 1'b0);
			chk_bit(clk_stop, 1'b0);
		end
		rd(OFS_RST_CAUSE, 8'h01);
		rd(OFS_IRQ_STATUS, 8'h02);
		wr(OFS_IRQ_STATUS, 8'h02);
		wr(OFS_UV_CTRL, 8'h00);
		endtest("reset mode");
		// interrupt mode, low before setup, then masked
		wr(OFS_IRQ_MASK, 8'h02);
		@(posedge clk_sys);
		below_lvl <= 1'b1;
		wr(OFS_UV_CTRL, 8'h80);
		step(1);
		chk_bit(irq, 1'b1);
		chk_bit(rst_uv, 1'b0);
		@(posedge clk_sys);
		below_lvl <= 1'b0;
		wr(OFS_IRQ_STATUS, 8'h01);
		chk_bit(irq, 1'b0);
		rd(OFS_IRQ_STATUS, 8'h00);
		wr(OFS_IRQ_MASK, 8'h03);
		@(posedge clk_sys);
		below_lvl <= 1'b1;
		step(1);
		chk_bit(irq, 1'b0);
		rd(OFS_IRQ_STATUS, 8'h01);
		@(posedge clk_sys);
		below_lvl <= 1'b0;
		wr(OFS_IRQ_STATUS, 8'h01);
		endtest("interrupt");
		// supply-rise reset clears causes and block state
		@(posedge clk_sys);
		wdog <= 1'b1;
		@(posedge clk_sys);
		wdog <= 1'b0;
		step(1);
		rd(OFS_RST_CAUSE, 8'h11);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			below_rise <= 1'b1;
			step(1);
			chk_bit(rst_rise, 1'b1);
			chk_bit(clk_stop, 1'b1);
			@(posedge clk_sys);
			below_rise <= 1'b0;
			step(1);
			chk_bit(rst_rise, 1'b0);
			rd(OFS_RST_CAUSE, 8'h00);
			rd(OFS_UV_CTRL, 8'h00);
			wr(OFS_UV_CTRL, 8'h80);
		end
		endtest("supply rise");
		// chip reset in mid-run
		wr(OFS_IRQ_MASK, 8'h00);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		step(2);
		chk_bit(clk_stop, 1'b1);
		chk_bit(uv_enable, 1'b0);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(OFS_UV_CTRL, RST_UV_CTRL);
		rd(OFS_IRQ_MASK, {6'h00, RST_IRQ_MASK});
		endtest("chip reset");
		conclude();
	end
endmodule : supply_voltage_reset_monitor_test
